//--- common/tppio_defines.vh
// Summary of operation
// - data read gives latch or live pin
// - input mode data write reconfigures input
// - direction bit zero input, one output
// - option zero open-drain, one push-pull
// - input mode option bit changes configuration
// - reset clears all six registers
// - registers decoded at fixed data addresses
// - option and data select input mode
// - interrupt needs global interrupt enable set
// - bit x controls pin x
`ifndef TPPIO_DEFINES_VH
`define TPPIO_DEFINES_VH
`define TPPIO_ADDR_DATA_A 8'hc0
`define TPPIO_ADDR_DATA_B 8'hc1
`define TPPIO_ADDR_DIR_A 8'hc4
`define TPPIO_ADDR_DIR_B 8'hc5
`define TPPIO_ADDR_OPT_A 8'hcc
`define TPPIO_ADDR_OPT_B 8'hcd
`define TPPIO_RESET_VALUE 8'h00
`define TPPIO_PULLUP_RESET 8'hff
`define TPPIO_WIDTH 8
`endif

//--- core/tppio_sync.v
`timescale 1ns/10ps
module tppio_sync (
  input wire i_ref_clk,
  input wire i_reset,
  input wire [7:0] i_async,
  output reg [7:0] o_level
);
  reg [7:0] s1_reg;
  reg [7:0] s2_reg;
  reg [7:0] s3_reg;
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
      o_level <= 8'h00;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // accept a change once the later two stages agree
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end
endmodule

//--- core/tppio_pin_cfg.v
`timescale 1ns/10ps
module tppio_pin_cfg (
  input wire [7:0] i_dir,
  input wire [7:0] i_opt,
  input wire [7:0] i_latch,
  input wire i_gen,
  output wire [7:0] o_out,
  output wire [7:0] o_oe,
  output wire [7:0] o_pullup,
  output wire [7:0] o_irq_en,
  output wire [7:0] o_analog
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bit
      wire in_mode = ~i_dir[g];
      assign o_out[g] = i_latch[g];
      assign o_oe[g] = i_dir[g] & (i_opt[g] | ~i_latch[g]);
      assign o_pullup[g] = in_mode & ~i_latch[g];
      assign o_irq_en[g] = in_mode & i_opt[g] & ~i_latch[g] & i_gen;
      assign o_analog[g] = in_mode & i_opt[g] & i_latch[g];
    end
  endgenerate
endmodule

//--- core/tppio_top.v
`timescale 1ns/10ps
`include "tppio_defines.vh"
module tppio_top (
  input wire i_ref_clk,
  input wire i_reset,
  // register bus
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // pin side
  input wire i_global_interrupt_enable,
  input wire [7:0] i_pin_a,
  input wire [7:0] i_pin_b,
  output reg [7:0] o_pin_a,
  output reg [7:0] o_pin_a_oe,
  output reg [7:0] o_pin_b,
  output reg [7:0] o_pin_b_oe,
  // input mode controls
  output reg [7:0] o_pullup_a,
  output reg [7:0] o_pullup_b,
  output reg [7:0] o_irq_a,
  output reg [7:0] o_irq_b,
  output reg [7:0] o_analog_a,
  output reg [7:0] o_analog_b
);
  reg [7:0] data_a_reg;
  reg [7:0] data_b_reg;
  reg [7:0] dir_a_reg;
  reg [7:0] dir_b_reg;
  reg [7:0] opt_a_reg;
  reg [7:0] opt_b_reg;
  reg [7:0] data_a_next;
  reg [7:0] data_b_next;
  reg [7:0] dir_a_next;
  reg [7:0] dir_b_next;
  reg [7:0] opt_a_next;
  reg [7:0] opt_b_next;
  reg [7:0] rdata_next;
  wire [7:0] lvl_a;
  wire [7:0] lvl_b;
  wire [7:0] view_a;
  wire [7:0] view_b;
  wire [7:0] out_a;
  wire [7:0] oe_a;
  wire [7:0] pu_a;
  wire [7:0] ie_a;
  wire [7:0] an_a;
  wire [7:0] out_b;
  wire [7:0] oe_b;
  wire [7:0] pu_b;
  wire [7:0] ie_b;
  wire [7:0] an_b;
  // one write strobe per register; unmapped writes hit none
  wire wr_data_a = i_wr & (i_addr == `TPPIO_ADDR_DATA_A);
  wire wr_data_b = i_wr & (i_addr == `TPPIO_ADDR_DATA_B);
  wire wr_dir_a = i_wr & (i_addr == `TPPIO_ADDR_DIR_A);
  wire wr_dir_b = i_wr & (i_addr == `TPPIO_ADDR_DIR_B);
  wire wr_opt_a = i_wr & (i_addr == `TPPIO_ADDR_OPT_A);
  wire wr_opt_b = i_wr & (i_addr == `TPPIO_ADDR_OPT_B);
  genvar b;

  // three-stage filters on the live pin levels
  tppio_sync u_sync_a (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_pin_a),
    .o_level(lvl_a)
  );
  tppio_sync u_sync_b (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_pin_b),
    .o_level(lvl_b)
  );

  // per-pin mode decode
  tppio_pin_cfg u_cfg_a (
    .i_dir(dir_a_reg),
    .i_opt(opt_a_reg),
    .i_latch(data_a_reg),
    .i_gen(i_global_interrupt_enable),
    .o_out(out_a),
    .o_oe(oe_a),
    .o_pullup(pu_a),
    .o_irq_en(ie_a),
    .o_analog(an_a)
  );

  tppio_pin_cfg u_cfg_b (
    .i_dir(dir_b_reg),
    .i_opt(opt_b_reg),
    .i_latch(data_b_reg),
    .i_gen(i_global_interrupt_enable),
    .o_out(out_b),
    .o_oe(oe_b),
    .o_pullup(pu_b),
    .o_irq_en(ie_b),
    .o_analog(an_b)
  );

  // read view: latch for outputs, synced level for inputs
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_view
      assign view_a[b] = dir_a_reg[b] ? data_a_reg[b] : lvl_a[b];
      assign view_b[b] = dir_b_reg[b] ? data_b_reg[b] : lvl_b[b];
    end
  endgenerate

  // register read select; unmapped reads give zero
  always @* begin
    case (i_addr)
      `TPPIO_ADDR_DATA_A: rdata_next = view_a;
      `TPPIO_ADDR_DATA_B: rdata_next = view_b;
      `TPPIO_ADDR_DIR_A: rdata_next = dir_a_reg;
      `TPPIO_ADDR_DIR_B: rdata_next = dir_b_reg;
      `TPPIO_ADDR_OPT_A: rdata_next = opt_a_reg;
      `TPPIO_ADDR_OPT_B: rdata_next = opt_b_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end
  end

  // each register: next value, then flop
  always @* begin
    data_a_next = data_a_reg;
    if (wr_data_a) begin
      data_a_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      data_a_reg <= `TPPIO_RESET_VALUE;
    end else begin
      data_a_reg <= data_a_next;
    end
  end

  always @* begin
    data_b_next = data_b_reg;
    if (wr_data_b) begin
      data_b_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      data_b_reg <= `TPPIO_RESET_VALUE;
    end else begin
      data_b_reg <= data_b_next;
    end
  end

  always @* begin
    dir_a_next = dir_a_reg;
    if (wr_dir_a) begin
      dir_a_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      dir_a_reg <= `TPPIO_RESET_VALUE;
    end else begin
      dir_a_reg <= dir_a_next;
    end
  end

  always @* begin
    dir_b_next = dir_b_reg;
    if (wr_dir_b) begin
      dir_b_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      dir_b_reg <= `TPPIO_RESET_VALUE;
    end else begin
      dir_b_reg <= dir_b_next;
    end
  end

  always @* begin
    opt_a_next = opt_a_reg;
    if (wr_opt_a) begin
      opt_a_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      opt_a_reg <= `TPPIO_RESET_VALUE;
    end else begin
      opt_a_reg <= opt_a_next;
    end
  end

  always @* begin
    opt_b_next = opt_b_reg;
    if (wr_opt_b) begin
      opt_b_next = i_wdata;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      opt_b_reg <= `TPPIO_RESET_VALUE;
    end else begin
      opt_b_reg <= opt_b_next;
    end
  end

  // pin side registered, one cycle behind the registers
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_a <= 8'h00;
    end else begin
      o_pin_a <= out_a;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_a_oe <= 8'h00;
    end else begin
      o_pin_a_oe <= oe_a;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_b <= 8'h00;
    end else begin
      o_pin_b <= out_b;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_b_oe <= 8'h00;
    end else begin
      o_pin_b_oe <= oe_b;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pullup_a <= `TPPIO_PULLUP_RESET;
    end else begin
      o_pullup_a <= pu_a;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pullup_b <= `TPPIO_PULLUP_RESET;
    end else begin
      o_pullup_b <= pu_b;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_irq_a <= 8'h00;
    end else begin
      o_irq_a <= ie_a;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_irq_b <= 8'h00;
    end else begin
      o_irq_b <= ie_b;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_analog_a <= 8'h00;
    end else begin
      o_analog_a <= an_a;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_analog_b <= 8'h00;
    end else begin
      o_analog_b <= an_b;
    end
  end
endmodule

//--- verif/tppio_asserts.sv
`timescale 1ns/10ps
module tppio_asserts (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_rd,
  input wire i_global_interrupt_enable,
  input wire [7:0] o_rdata,
  input wire [7:0] o_pin_a,
  input wire [7:0] o_pin_a_oe,
  input wire [7:0] o_pullup_a,
  input wire [7:0] o_irq_a,
  input wire [7:0] o_analog_a
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_dir; (o_pullup_a & o_pin_a_oe) == 8'h00; endproperty
  a_dir: assert property (p_dir) else $error("pullup on output");
  property p_od; (~o_pin_a_oe & ~o_pin_a & ~o_pullup_a) == 8'h00; endproperty
  a_od: assert property (p_od) else $error("low not driven");
  property p_pd; (o_pullup_a & o_pin_a) == 8'h00; endproperty
  a_pd: assert property (p_pd) else $error("pullup data high");
  property p_pu; (o_irq_a & ~o_pullup_a) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("irq no pullup");
  property p_an; (o_analog_a & ~o_pin_a) == 8'h00; endproperty
  a_an: assert property (p_an) else $error("analog data low");
  property p_gen; !$past(i_global_interrupt_enable) |-> o_irq_a == 8'h00; endproperty
  a_gen: assert property (p_gen) else $error("irq not gated");
  sequence s_idle; o_pin_a_oe == 8'h00 ##1 o_pullup_a == 8'hff; endsequence
  property p_rst; $fell(i_reset) |-> s_idle; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_hold; !i_rd |=> $stable(o_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind tppio_top tppio_asserts u_chk (.*);

//--- verif/tppio_pins.sv
`timescale 1ns/10ps
module tppio_pins (
  input wire [7:0] i_out,
  input wire [7:0] i_oe,
  input wire [7:0] i_pu,
  input wire [7:0] i_ext,
  output wire [7:0] o_pin
);
  // undriven, unpulled pins follow the outside level
  assign o_pin = (i_oe & i_out) | (~i_oe & (i_pu | i_ext));
endmodule

//--- verif/two_port_pin_config_io_tb.sv
`timescale 1ns/10ps
module two_port_pin_config_io_tb;
  reg c = 0, r = 1, w = 0, rd = 0, g = 0, s;
  reg [7:0] a = 0, wd = 0, e = 0, d, o, q;
  wire [7:0] rq, pa, pb, xa, oa, xb, ob, ua, ub, ia, ib, na, nb;
  integer fails = 0, checked = 0, i;
  initial forever #12.5 c = ~c;
  tppio_top DUT (.i_ref_clk(c), .i_reset(r), .i_addr(a), .i_wdata(wd), .i_wr(w), .i_rd(rd), .o_rdata(rq),
    .i_global_interrupt_enable(g), .i_pin_a(pa), .i_pin_b(pb), .o_pin_a(xa), .o_pin_a_oe(oa), .o_pin_b(xb),
    .o_pin_b_oe(ob), .o_pullup_a(ua), .o_pullup_b(ub), .o_irq_a(ia), .o_irq_b(ib), .o_analog_a(na),
    .o_analog_b(nb));
  tppio_pins pm_a (.i_out(xa), .i_oe(oa), .i_pu(ua), .i_ext(e), .o_pin(pa));
  tppio_pins pm_b (.i_out(xb), .i_oe(ob), .i_pu(ub), .i_ext(~e), .o_pin(pb));
  function [7:0] rx(input [7:0] m, v, x);
    rx = (m & v) | (~m & ~v) | (~m & v & x);
  endfunction
  function [7:0] pw(input [7:0] m, n, v, x);
    pw = (m & v & (n | x)) | (~m & (~v | x));
  endfunction
  task cmp(input [7:0] y, input [7:0] x); begin
    checked = checked + 1;
    if (y !== x) begin
      fails = fails + 1;
      $display("MISMATCH %0t got %h want %h", $time, y, x);
    end
  end endtask
  task acc(input wn, input [7:0] ad, input [7:0] v); begin
    @(posedge c);
    #2 w = wn;
    rd = !wn;
    a = ad;
    wd = v;
    @(posedge c);
    #2 w = 0;
    rd = 0;
  end endtask
  task chk(input [7:0] ad, input [7:0] x); begin
    acc(0, ad, 8'h00);
    cmp(rq, x);
  end endtask
  task final_report; begin
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end endtask
  initial begin
    #200000;
    fails = fails + 1;
    final_report;
  end
  initial begin
    i = $urandom(99);
    repeat (12) @(posedge c);
    #2 r = 0;
    repeat (3) @(posedge c);
    chk(8'hc1, 8'hff);
    chk(8'hc4, 8'h00);
    chk(8'hcd, 8'h00);
    chk(8'hc2, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      {d, o, q, e} = $urandom;
      if (i < 4) begin
        d = {8{i[1]}};
        o = 8'hf0;
        q = 8'hcc;
      end
      s = i[0];
      g = d[0] ^ q[7];
      acc(1, 8'hc0 + s, q);
      acc(1, 8'hc4 + s, d);
      acc(1, 8'hcc + s, o);
      repeat (5) @(posedge c);
      chk(8'hc0 + s, rx(d, q, s ? ~e : e));
      chk(8'hc4 + s, d);
      chk(8'hcc + s, o);
      cmp(s ? ib : ia, ~d & o & ~q & {8{g}});
      cmp(s ? nb : na, ~d & o & q);
      cmp(s ? ob : oa, d & (o | ~q));
      cmp(s ? ub : ua, ~d & ~q);
      cmp(s ? xb : xa, q);
      cmp(s ? pb : pa, pw(d, o, q, s ? ~e : e));
    end
    acc(1, 8'hc5, 8'hff);
    chk(8'hc5, 8'hff);
    @(posedge c);
    #2 r = 1;
    repeat (2) @(posedge c);
    #2 cmp(ub, 8'hff);
    r = 0;
    repeat (4) @(posedge c);
    chk(8'hc5, 8'h00);
    cmp(ua, 8'hff);
    cmp(oa, 8'h00);
    final_report;
  end
endmodule
